// ### atc_config_dev.sv
/*
 * Device end: receives 16-bit serial command words, holds the
 * frequency-control and transmit configuration words, and runs the
 * offset measurement, clamping and transmit frequency arithmetic.
 * Assumes link wires synchronous to clk and a host keeping its rules.
 */
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Code c4 writes frequency-control word
// (R2) Auto mode picks when measurements run
// (R3) Range field clamps stored offset
// (R4) Step size follows selected band
// (R5) Strobe one starts one manual sample
// (R6) Host clears strobe before next sample
// (R7) Store offset only when apply set
// (R8) Apply bit gates offset onto tuning
// (R9) Fine mode doubles measurement time
// (R10) Measure enable gates offset calculation
// (R11) Code 1001100 writes transmit word
// (R12) Polarity bit swaps deviation direction
// (R13) Deviation is (code+1) times 15 kHz
// (R14) Host writes reserved transmit bit zero
// (R15) Power code gives 2.5 dB steps
// (R16) Sign is polarity xor modulation data
// (R17) Frequency-control word resets to c4f7
// (R18) Transmit word resets to 9800
// (R19) Leading one marks write, zero read; the device has no read path and ignores words with a leading zero
// (R20) Host clears enable when reading offset
// (R21) Whole 16-bit word, MSB first, then apply
module atc_config_dev #(
	parameter int OFFSET_W = 6
) (
	input wire logic clk,
	input wire logic reset,
	atc_link_if.dev link,
	input wire logic [1:0] bandSelect,
	input wire logic dataIndicator,
	input wire logic modulationData,
	input wire logic signed [OFFSET_W-1:0] rawOffsetError,
	output logic [15:0] freqControlConfig,
	output logic [15:0] transmitConfig,
	output logic measureActive,
	output logic measureDone,
	output logic signed [OFFSET_W-1:0] storedOffset,
	output logic signed [OFFSET_W-1:0] appliedOffset,
	output logic [15:0] tuningStepHz,
	output logic signed [18:0] txFreqOffsetHz,
	output logic [11:0] powerAttenCentiDb
);
	typedef enum logic {ATC_MEAS_IDLE, ATC_MEAS_RUN} atc_meas_state_t;

	localparam int CNT_W = $clog2(2 * atc_pkg::MEAS_CYCLES + 1);
	localparam logic [CNT_W-1:0] MEAS_LEN = CNT_W'(atc_pkg::MEAS_CYCLES);

	logic sckPrev_reg;
	logic [15:0] shift_reg;
	logic [4:0] bitCnt_reg;
	logic [15:0] afc_reg;
	logic [15:0] tx_reg;
	logic strobeReq_reg;
	logic onceReq_reg;
	atc_meas_state_t meas_reg;
	atc_meas_state_t meas_next;
	logic [CNT_W-1:0] cnt_reg;
	logic signed [OFFSET_W-1:0] offset_reg;
	logic done_reg;
	logic signed [18:0] txOff_reg;
	logic [11:0] pwr_reg;

	// Serial word assembly
	wire sckRise = link.sck & ~sckPrev_reg;
	wire bitTaken = ~link.selN & sckRise & (bitCnt_reg != 5'd16);
	wire wordDone = bitTaken & (bitCnt_reg == 5'd15); // [R21]
	wire [15:0] newWord = {shift_reg[14:0], link.sdi};
	wire isWrite = newWord[atc_pkg::WRITE_FLAG_BIT]; // [R19]
	wire afcWrite = wordDone & isWrite & (newWord[15:8] == atc_pkg::AFC_CODE); // [R1]
	wire txWrite = wordDone & isWrite & (newWord[15:9] == atc_pkg::TX_CODE); // [R11]

	// Configuration fields
	wire [1:0] autoMode = afc_reg[atc_pkg::AUTO_LSB +: 2];
	wire [1:0] rangeCode = afc_reg[atc_pkg::RANGE_LSB +: 2];
	wire fineMode = afc_reg[atc_pkg::FINE_BIT];
	wire applyEn = afc_reg[atc_pkg::APPLY_BIT];
	wire measureEn = afc_reg[atc_pkg::MEASURE_BIT];
	wire polarity = tx_reg[atc_pkg::POL_BIT];
	wire [3:0] devCode = tx_reg[atc_pkg::DEV_LSB +: 4];
	wire [2:0] pwrCode = tx_reg[atc_pkg::PWR_LSB +: 3];

	// Rising strobe; a held one does not retrigger
	wire strobeSet = afcWrite & newWord[atc_pkg::STROBE_BIT] & ~afc_reg[atc_pkg::STROBE_BIT]; // [R5] [R6]

	// Start conditions per automatic mode
	wire autoStart = (autoMode == atc_pkg::ATC_AUTO_ALWAYS)
		| ((autoMode == atc_pkg::ATC_AUTO_RX_HOLD) & dataIndicator)
		| ((autoMode == atc_pkg::ATC_AUTO_ONCE) & onceReq_reg); // [R2]
	wire startMeas = (meas_reg == ATC_MEAS_IDLE) & measureEn & (strobeReq_reg | autoStart); // [R10]
	wire [CNT_W-1:0] measLen = fineMode ? CNT_W'(2 * atc_pkg::MEAS_CYCLES) : MEAS_LEN; // [R9]
	wire measEnd = (meas_reg == ATC_MEAS_RUN) & (cnt_reg == measLen - CNT_W'(1));

	// Offset clamp limits
	wire signed [OFFSET_W-1:0] limHi = (rangeCode == 2'h3) ? OFFSET_W'(3)
		: (rangeCode == 2'h2) ? OFFSET_W'(7)
		: (rangeCode == 2'h1) ? OFFSET_W'(15)
		: {1'b0, {(OFFSET_W-1){1'b1}}}; // [R3]
	wire signed [OFFSET_W-1:0] limLo = (rangeCode == 2'h3) ? -OFFSET_W'(4)
		: (rangeCode == 2'h2) ? -OFFSET_W'(8)
		: (rangeCode == 2'h1) ? -OFFSET_W'(16)
		: {1'b1, {(OFFSET_W-1){1'b0}}}; // [R3]
	wire signed [OFFSET_W-1:0] clamped = (rawOffsetError > limHi) ? limHi
		: (rawOffsetError < limLo) ? limLo : rawOffsetError;

	// Transmit arithmetic
	wire [17:0] devHz = 18'((5'(devCode) + 5'd1) * atc_pkg::DEV_STEP_HZ); // [R13]
	wire devNegative = polarity ^ modulationData; // [R12] [R16]
	wire signed [18:0] txOffNext = devNegative ? -$signed({1'b0, devHz}) : $signed({1'b0, devHz});
	wire [11:0] pwrNext = 12'(pwrCode * atc_pkg::PWR_STEP_CENTIDB); // [R15]

	always_comb begin
		meas_next = meas_reg;
		case (meas_reg)
			ATC_MEAS_IDLE: begin
				if (startMeas) begin
					meas_next = ATC_MEAS_RUN;
				end
			end
			ATC_MEAS_RUN: begin
				if (measEnd | ~measureEn) begin
					meas_next = ATC_MEAS_IDLE;
				end
			end
			default: meas_next = ATC_MEAS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sckPrev_reg <= 1'b0;
			shift_reg <= 16'h0000;
			bitCnt_reg <= 5'd0;
		end else begin
			sckPrev_reg <= link.sck;
			if (link.selN) begin
				bitCnt_reg <= 5'd0;
			end else if (bitTaken) begin
				shift_reg <= newWord;
				bitCnt_reg <= bitCnt_reg + 5'd1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			afc_reg <= atc_pkg::AFC_RESET; // [R17]
			tx_reg <= atc_pkg::TX_RESET; // [R18]
		end else begin
			if (afcWrite) begin
				afc_reg <= newWord;
			end
			if (txWrite) begin
				tx_reg <= newWord;
			end
		end
	end

	// Request flags; a new strobe wins over the clear by a start
	always_ff @(posedge clk) begin
		if (reset) begin
			strobeReq_reg <= 1'b0;
			onceReq_reg <= 1'b1;
		end else begin
			if (strobeSet) begin
				strobeReq_reg <= 1'b1;
			end else if (startMeas) begin
				strobeReq_reg <= 1'b0;
			end
			if (startMeas & (autoMode == atc_pkg::ATC_AUTO_ONCE)) begin
				onceReq_reg <= 1'b0; // [R2]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			meas_reg <= ATC_MEAS_IDLE;
			cnt_reg <= '0;
			offset_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			meas_reg <= meas_next;
			cnt_reg <= (meas_reg == ATC_MEAS_RUN) ? cnt_reg + CNT_W'(1) : '0;
			done_reg <= measEnd & measureEn;
			if (measEnd & measureEn & applyEn) begin
				offset_reg <= clamped; // [R7]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			txOff_reg <= '0;
			pwr_reg <= 12'h000;
		end else begin
			txOff_reg <= txOffNext;
			pwr_reg <= pwrNext;
		end
	end

	assign freqControlConfig = afc_reg;
	assign transmitConfig = tx_reg;
	assign measureActive = (meas_reg == ATC_MEAS_RUN);
	assign measureDone = done_reg;
	assign storedOffset = offset_reg;
	assign appliedOffset = applyEn ? offset_reg : '0; // [R8]
	assign tuningStepHz = (bandSelect == atc_pkg::BAND_433) ? atc_pkg::STEP_433_HZ
		: (bandSelect == atc_pkg::BAND_868) ? atc_pkg::STEP_868_HZ
		: (bandSelect == atc_pkg::BAND_915) ? atc_pkg::STEP_915_HZ : 16'h0000; // [R4]
	assign txFreqOffsetHz = txOff_reg;
	assign powerAttenCentiDb = pwr_reg;
endmodule : atc_config_dev

// ### atc_pkg.sv
/*
 * Shared constants for the frequency-control and transmit configuration
 * words: command codes, reset values, field positions, scaling figures
 * and the host controller's register map.
 * Assumes a 10 MHz system clock shared by both ends.
 */
package atc_pkg;
	localparam int WORD_W = 16;
	localparam int CLK_PERIOD_NS = 100;

	// Command decoding
	localparam logic [7:0] AFC_CODE = 8'hc4;
	localparam logic [6:0] TX_CODE = 7'h4c;
	localparam int WRITE_FLAG_BIT = 15;

	// Values after reset
	localparam logic [15:0] AFC_RESET = 16'hc4f7;
	localparam logic [15:0] TX_RESET = 16'h9800;

	// Frequency-control word fields
	localparam int AUTO_LSB = 6;
	localparam int RANGE_LSB = 4;
	localparam int STROBE_BIT = 3;
	localparam int FINE_BIT = 2;
	localparam int APPLY_BIT = 1;
	localparam int MEASURE_BIT = 0;

	// Transmit word fields
	localparam int POL_BIT = 8;
	localparam int DEV_LSB = 4;
	localparam int RSVD_BIT = 3;
	localparam int PWR_LSB = 0;

	typedef enum logic [1:0] {
		ATC_AUTO_HOST = 2'h0,
		ATC_AUTO_ONCE = 2'h1,
		ATC_AUTO_RX_HOLD = 2'h2,
		ATC_AUTO_ALWAYS = 2'h3
	} atc_auto_mode_t;

	// Band select codes and tuning step per band
	localparam logic [1:0] BAND_433 = 2'h1;
	localparam logic [1:0] BAND_868 = 2'h2;
	localparam logic [1:0] BAND_915 = 2'h3;
	localparam logic [15:0] STEP_433_HZ = 16'h09c4;
	localparam logic [15:0] STEP_868_HZ = 16'h1388;
	localparam logic [15:0] STEP_915_HZ = 16'h1d4c;

	// Deviation and power scaling
	localparam int DEV_STEP_HZ = 15000;
	localparam int PWR_STEP_CENTIDB = 250;

	// Offset measurement length in regular mode
	localparam int MEAS_TIME_NS = 1000;
	localparam int MEAS_CYCLES = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Host controller register map and serial clock divider
	localparam logic [11:0] CMD_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam int SCK_HALF_CYCLES = 2;
endpackage : atc_pkg

// ### atc_link_if.sv
/*
 * Serial command link between host controller and configuration bank.
 * Assumes the host drives every wire; the device only listens.
 */
`timescale 1ns/1ps
interface atc_link_if;
	logic sck;
	logic selN;
	logic sdi;

	modport host (output sck, output selN, output sdi);
	modport dev (input sck, input selN, input sdi);
endinterface : atc_link_if

// ### atc_config_host.sv
/*
 * Host end: an APB slave taking 16-bit command words from software and
 * sending each as one serial frame, MSB first, on the link.
 * Assumes software polls the busy flag before writing the next command.
 */
`timescale 1ns/1ps
module atc_config_host #(
	parameter int HALF_CYCLES = atc_pkg::SCK_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	atc_link_if.host link
);
	typedef enum logic {ATC_HOST_IDLE, ATC_HOST_SEND} atc_host_state_t;

	localparam int DIV_W = $clog2(HALF_CYCLES + 1);

	atc_host_state_t state_reg;
	logic [15:0] word_reg;
	logic [15:0] shift_reg;
	logic [4:0] half_reg;
	logic [DIV_W-1:0] div_reg;
	logic sck_reg;
	logic [31:0] rdata_reg;

	wire busy = (state_reg == ATC_HOST_SEND);
	wire setupPhase = psel & ~penable;
	wire access = psel & penable;
	wire hitCmd = (paddr == atc_pkg::CMD_OFFSET);
	wire hitStatus = (paddr == atc_pkg::STATUS_OFFSET);
	wire cmdWrite = access & pwrite & hitCmd & ~busy;
	wire badAccess = access & ((~hitCmd & ~hitStatus) | (pwrite & (hitStatus | busy)));
	wire isTxWord = (pwdata[15:9] == atc_pkg::TX_CODE); // [R11]
	wire [15:0] cmdWord = isTxWord ? (pwdata[15:0] & ~(16'h0001 << atc_pkg::RSVD_BIT))
		: pwdata[15:0]; // [R14]
	wire halfTick = busy & (div_reg == DIV_W'(HALF_CYCLES - 1));
	wire frameEnd = halfTick & (half_reg == 5'd31); // [R21]
	wire [31:0] rdataNext = hitCmd ? {16'h0000, word_reg}
		: hitStatus ? {31'h0, busy} : 32'h0;

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= ATC_HOST_IDLE;
			word_reg <= 16'h0000;
			shift_reg <= 16'h0000;
			half_reg <= 5'd0;
			div_reg <= '0;
			sck_reg <= 1'b0;
		end else begin
			case (state_reg)
				ATC_HOST_IDLE: begin
					if (cmdWrite) begin
						word_reg <= cmdWord;
						shift_reg <= cmdWord;
						half_reg <= 5'd0;
						div_reg <= '0;
						state_reg <= ATC_HOST_SEND;
					end
				end
				ATC_HOST_SEND: begin
					div_reg <= halfTick ? '0 : div_reg + DIV_W'(1);
					if (halfTick) begin
						half_reg <= half_reg + 5'd1;
						sck_reg <= ~sck_reg;
						// Next bit goes out on the falling edge
						if (sck_reg) begin
							shift_reg <= {shift_reg[14:0], 1'b0};
						end
					end
					if (frameEnd) begin
						state_reg <= ATC_HOST_IDLE;
					end
				end
				default: state_reg <= ATC_HOST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_reg <= 32'h0;
		end else if (setupPhase) begin
			rdata_reg <= rdataNext;
		end
	end

	assign prdata = rdata_reg;
	assign pready = 1'b1;
	assign pslverr = badAccess;
	assign link.sck = sck_reg;
	assign link.selN = ~busy;
	assign link.sdi = shift_reg[15]; // [R19]
endmodule : atc_config_host

// ### atc_chk.sv
/* Link checker: shape and timing of each serial command frame.
 * Assumes the host default of two clk cycles per sck half. */
`timescale 1ns/1ps
module atc_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic sck,
	input wire logic selN,
	input wire logic sdi
);
	logic [6:0] lowCnt_reg;
	logic [4:0] riseCnt_reg;
	logic sck_reg;
	wire riseSeen = sck && !sck_reg;
	wire frameOff = reset || selN;

	always_ff @(posedge clk) begin
		sck_reg <= sck;
		lowCnt_reg <= frameOff ? 7'h00 : lowCnt_reg + 7'h01;
		riseCnt_reg <= frameOff ? 5'h00 : riseCnt_reg + 5'(riseSeen);
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	a_idle_sck_low: assert property (selN |-> !sck)
		else $error("sck high while idle");
	a_frame_start: assert property ($fell(selN) |-> !sck ##1 !sck ##1 sck)
		else $error("bad frame start");
	a_high_half: assert property ($rose(sck) |=> sck ##1 !sck)
		else $error("sck high half length");
	a_low_half: assert property ($fell(sck) && !selN |=> !sck ##1 sck)
		else $error("sck low half length");
	a_sdi_on_fall: assert property (!selN && !$past(selN) && $changed(sdi) |-> $fell(sck))
		else $error("sdi moved off sck fall");
	a_frame_len: assert property ($rose(selN) |-> lowCnt_reg == 7'h40)
		else $error("frame length");
	a_frame_bits: assert property ($rose(selN) |-> riseCnt_reg == 5'h10 && $fell(sck))
		else $error("frame bit count");
	a_reset_idle: assert property (disable iff (1'b0) reset |=> selN && !sck)
		else $error("link not idle in reset");

	cover property ($rose(selN));
	cover property ($rose(selN) ##[1:20] $fell(selN));
	cover property (!selN && $rose(sck) && sdi);
endmodule : atc_chk

// ### afc_and_tx_config_regs_tb.sv
/* Bench: host and device joined by the link, driven over APB.
 * Assumes zero-wait APB and the package register map. */
`timescale 1ns/1ps
module afc_and_tx_config_regs_tb;
	logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic dataIndicator = 1'b0, modulationData = 1'b0, pready, pslverr, mActive, mDone;
	logic [1:0] bandSelect = 2'h1;
	logic [11:0] paddr = 12'h000, pwrC;
	logic [15:0] fcc, txc, step, mon, w;
	logic [15:0] sentQ[$];
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'he842;
	logic signed [5:0] rawOffsetError = 6'sh00, stOff, apOff;
	logic signed [18:0] txHz;
	int n_mismatch = 0, n_compared = 0, nDone = 0, runN = 0, lastLen = 0, d0, e, i, j, k;
	atc_link_if link ();
	atc_config_host atc_config_host_i (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	atc_config_dev atc_config_dev_i (.clk(clk), .reset(reset), .link(link),
		.bandSelect(bandSelect), .dataIndicator(dataIndicator),
		.modulationData(modulationData), .rawOffsetError(rawOffsetError),
		.freqControlConfig(fcc), .transmitConfig(txc), .measureActive(mActive),
		.measureDone(mDone), .storedOffset(stOff), .appliedOffset(apOff),
		.tuningStepHz(step), .txFreqOffsetHz(txHz), .powerAttenCentiDb(pwrC));
	atc_chk atc_chk_i (.clk(clk), .reset(reset), .sck(link.sck), .selN(link.selN),
		.sdi(link.sdi));

	initial forever #50 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	function automatic logic [31:0] rnd;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic int clampv(input int v, input int r);
		int lim;
		lim = r == 0 ? 64 : 32 >> r;
		return v >= lim ? lim - 1 : v < -lim ? -lim : v;
	endfunction : clampv

	// Wire model: shift in at each sck rise, compare at frame end
	always @(posedge link.sck) if (!link.selN) mon = {mon[14:0], link.sdi};
	always @(posedge link.selN) begin
		if (!reset && sentQ.size() == 0) chk(1, 0);
		else if (!reset) chk(mon, sentQ.pop_front());
	end
	always @(posedge clk) begin
		if (mDone === 1'b1) nDone++;
		if (mActive === 1'b1) runN++;
		else if (runN != 0) begin
			lastLen = runN;
			runN = 0;
		end
	end

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) tmo;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic tmo;
		n_mismatch++;
		end_sim;
	endtask : tmo

	task automatic idle;
		for (j = 0; j < 50; j++) begin
			apb(1'b0, atc_pkg::STATUS_OFFSET, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		if (j == 50) tmo;
	endtask : idle

	// Host clears the reserved transmit bit on the wire
	task automatic send(input logic [15:0] v);
		sentQ.push_back(v[15:9] == 7'h4c ? v & 16'hfff7 : v);
		apb(1'b1, atc_pkg::CMD_OFFSET, {16'h0, v});
		chk(err, 0);
		idle;
	endtask : send

	task automatic wait_done;
		for (k = 0; k < 60 && nDone == d0; k++) @(negedge clk);
		if (nDone == d0) tmo;
	endtask : wait_done

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk(fcc, 16'hc4f7);
		chk(txc, 16'h9800);
		chk(txHz, 0);
		@(negedge clk);
		chk(txHz, 15000);
		chk(pwrC, 0);
		for (k = 0; k < 8 && mActive !== 1'b1; k++) @(negedge clk);
		chk(mActive, 1);
		for (i = 0; i < 4; i++) begin
			@(posedge clk) bandSelect <= i[1:0];
			@(negedge clk) chk(step, i * 2500);
		end
		send(16'hc400);
		chk(fcc, 16'hc400);
		d0 = nDone;
		send(16'hc408);
		chk(nDone, d0);
		chk(mActive, 0);
		send(16'h4477);
		send(16'hc277);
		chk(fcc, 16'hc408);
		apb(1'b1, 12'h008, 32'h0);
		chk(err, 1);
		for (i = 0; i < 4; i++) begin
			w = {8'hc4, 2'h0, i[1:0], 1'b1, i[0], 2'h3};
			send(w & 16'hfff7);
			rawOffsetError <= i % 2 ? 6'sh14 : 6'sh2c;
			d0 = nDone;
			send(w);
			wait_done;
			e = clampv(i % 2 ? 20 : -20, i);
			chk(lastLen, atc_pkg::MEAS_CYCLES * (i % 2 + 1));
			chk(stOff, e);
			chk(apOff, e);
		end
		send(16'hc401);
		rawOffsetError <= 6'sh2c;
		d0 = nDone;
		send(16'hc409);
		wait_done;
		chk(nDone, d0 + 1);
		send(16'hc408);
		chk(stOff, 3);
		chk(apOff, 0);
		send(16'hc480);
		d0 = nDone;
		send(16'hc481);
		chk(nDone, d0);
		dataIndicator <= 1'b1;
		repeat (30) @(negedge clk);
		chk(nDone > d0, 1);
		// Run-once mode: one measurement, then none
		send(16'hc440);
		d0 = nDone;
		send(16'hc441);
		repeat (60) @(negedge clk);
		chk(nDone, d0 + 1);
		@(posedge clk);
		for (i = 0; i < 16; i++) begin
			e = rnd();
			w = {7'h4c, e[8], i[3:0], e[3], i[2:0]};
			modulationData <= e[9];
			send(w);
			chk(txc, w & 16'hfff7);
			apb(1'b0, atc_pkg::CMD_OFFSET, 32'h0);
			chk(rd, {16'h0, w & 16'hfff7});
			d0 = (i + 1) * 15000;
			chk(txHz, (w[8] ^ modulationData) ? -d0 : d0);
			chk(pwrC, i % 8 * 250);
		end
		sentQ.push_back(16'h98f0);
		apb(1'b1, atc_pkg::CMD_OFFSET, 32'h98f0);
		apb(1'b1, atc_pkg::CMD_OFFSET, 32'h9807);
		chk(err, 1);
		idle;
		chk(txc, 16'h98f0);
		chk(sentQ.size(), 0);
		end_sim;
	end
endmodule : afc_and_tx_config_regs_tb
